/* hw/cims_pkg.sv */
`default_nettype none
package cims_pkg;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 8;
  localparam int          SYNC_W        = 28;
  // Master clock counts as absent after this long without an edge.
  localparam int          MCLK_TMO_NS   = 1000;
  localparam int          MCLK_TMO_CYC  = MCLK_TMO_NS / CLK_PERIOD_NS;
  // Wait-state length on the ready/acknowledge pin.
  localparam int          WAIT_NS       = 40;
  localparam int          WAIT_CYC      = (WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BOOT_CYC      = 2;
  localparam logic [4:0]  CFG_ADDR      = 5'h00;
  localparam logic [4:0]  EFE_ADDR      = 5'h1f;
  localparam logic [7:0]  REG_RST       = 8'h00;
  localparam logic [7:0]  EFE_GOOD      = 8'hff;
  localparam int          CFG_TS_LSB    = 0;
  localparam int          CFG_EDGE_BIT  = 3;
  localparam int          CFG_OE_BIT    = 4;
  localparam int          CMD_RD_BIT    = 7;
  localparam logic [1:0]  LVL_LOW       = 2'h0;
  localparam logic [1:0]  LVL_MID       = 2'h1;
  localparam logic [1:0]  LVL_HIGH      = 2'h3;
  localparam logic [2:0]  PAR_NM_DS     = 3'h4;
  localparam logic [2:0]  PAR_NM_RW     = 3'h5;
  localparam logic [2:0]  PAR_MX_DS     = 3'h6;
  localparam logic [2:0]  PAR_MX_RW     = 3'h7;
  typedef enum logic [1:0] {CIMS_HW = 2'h0, CIMS_SER = 2'h1, CIMS_PAR = 2'h3} cims_method_e;
  typedef enum logic [1:0] {PA_IDLE = 2'h0, PA_WAIT = 2'h1, PA_DONE = 2'h3} cims_pstate_e;
  function automatic logic cims_fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction : cims_fell
endpackage : cims_pkg
`default_nettype wire

/* hw/cims_reg_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface cims_reg_if;
  import cims_pkg::*;
  logic              we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] cfg;
  logic              efe_ok;
  modport master (output we, addr, wdata, input rdata, cfg, efe_ok);
  modport store  (input we, addr, wdata, output rdata, cfg, efe_ok);
endinterface : cims_reg_if
`default_nettype wire

/* hw/cims_regfile.sv */
`timescale 1ns/1ns
`default_nettype none
module cims_regfile (
  input  wire logic clk,
  input  wire logic rst_n,
  cims_reg_if.store rif
);
  import cims_pkg::*;
  logic [DATA_W-1:0] mem_q [2**ADDR_W];

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem_q[i] <= REG_RST;
      end
    end else if (rif.we) begin
      mem_q[rif.addr] <= rif.wdata;
    end
  end

  assign rif.rdata  = mem_q[rif.addr];
  assign rif.cfg    = mem_q[CFG_ADDR];
  // The front end only works once every bit of this setting is one.
  assign rif.efe_ok = (mem_q[EFE_ADDR] == EFE_GOOD);

  a_efe_write: assert property (@(posedge clk) disable iff (!rst_n)
    rif.we && rif.addr == EFE_ADDR && rif.wdata == EFE_GOOD |=> rif.efe_ok)
    else $error("front-end setting check wrong after write");
  a_reg_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !rif.we |=> $stable(mem_q[EFE_ADDR]))
    else $error("register changed without a write");
endmodule : cims_regfile
`default_nettype wire

/* hw/cims_ctrl_if.sv */
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module cims_ctrl_if (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic [1:0]                    method_level,
  input  wire logic                          bus_multiplex_strap,
  input  wire logic                          bus_style_strap,
  input  wire logic                          cs_n,
  input  wire logic                          sclk_ale,
  input  wire logic                          serial_data_in,
  input  wire logic                          write_or_data_strobe,
  input  wire logic                          read_or_dir,
  input  wire logic [cims_pkg::ADDR_W-1:0]   host_addr,
  input  wire logic [cims_pkg::DATA_W-1:0]   host_data_in,
  input  wire logic [2:0]                    template_select,
  input  wire logic                          clock_edge_select,
  input  wire logic                          output_enable_pin,
  input  wire logic                          mclk,
  input  wire logic                          irq_req,
  output logic [cims_pkg::DATA_W-1:0]        host_data_out,
  output logic                               host_data_oe,
  output logic                               serial_data_out,
  output logic                               serial_data_oe,
  output logic                               int_n,
  output logic                               ready_ack,
  output logic [1:0]                         method,
  output logic [2:0]                         cfg_template,
  output logic                               cfg_clock_edge,
  output logic                               cfg_output_enable,
  output logic                               efe_ok
);
  import cims_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] raw, meta_q, sync_q, prev_q;
  assign raw = {method_level, bus_multiplex_strap, bus_style_strap, cs_n, sclk_ale, serial_data_in,
                write_or_data_strobe, read_or_dir, host_addr, host_data_in, template_select,
                clock_edge_select, output_enable_pin, mclk};
  for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
        prev_q[g] <= 1'b0;
      end else begin
        meta_q[g] <= raw[g];
        sync_q[g] <= meta_q[g];
        prev_q[g] <= sync_q[g];
      end
    end
  end
  wire [1:0]        s_lvl  = sync_q[27:26];
  wire              s_mux  = sync_q[25];
  wire              s_sty  = sync_q[24];
  wire              s_cs_n = sync_q[23];
  wire              s_sclk = sync_q[22];
  wire              s_sdi  = sync_q[21];
  wire              s_wr   = sync_q[20];
  wire              s_rd   = sync_q[19];
  wire [ADDR_W-1:0] s_addr = sync_q[18:14];
  wire [DATA_W-1:0] s_data = sync_q[13:6];
  wire [2:0]        s_ts   = sync_q[5:3];
  wire              s_edge = sync_q[2];
  wire              s_oe   = sync_q[1];
  wire              s_mclk = sync_q[0];
  wire              cs_fell   = cims_fell(prev_q[23], sync_q[23]);
  wire              ale_fell  = cims_fell(prev_q[22], sync_q[22]);
  wire              sclk_rise = cims_fell(sync_q[22], prev_q[22]);
  // Edges are ignored until both stages hold the pin, so reset cannot fake one.
  wire              mclk_edge = (sync_q[0] ^ prev_q[0]) & (boot_q == 2'h3);

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  logic [1:0]   boot_q;
  cims_method_e meth_q;
  logic         mux_q, sty_q;
  wire          capture = (boot_q == 2'(BOOT_CYC));
  cims_method_e meth_d;
  assign meth_d = (s_lvl == LVL_LOW) ? CIMS_HW : (s_lvl == LVL_MID) ? CIMS_SER : CIMS_PAR;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boot_q <= 2'h0;
      meth_q <= CIMS_HW;
      mux_q  <= 1'b0;
      sty_q  <= 1'b0;
    end else begin
      if (boot_q != 2'h3) boot_q <= boot_q + 2'h1;
      if (capture) begin
        meth_q <= meth_d;
        mux_q  <= s_mux;
        sty_q  <= s_sty;
      end
    end
  end
  wire       par_sel  = (meth_q == CIMS_PAR) & ~s_cs_n;
  wire       ser_sel  = (meth_q == CIMS_SER) & ~s_cs_n;
  wire [2:0] par_code = {1'b1, mux_q, sty_q};

  // ---------------------------------------------------------------
  // Master clock presence
  // ---------------------------------------------------------------
  logic [8:0] mto_q;
  wire        mclk_ok = (mto_q != 9'h0);
  always_ff @(posedge clk) begin
    if (!rst_n) mto_q <= 9'h0;
    else if (mclk_edge) mto_q <= 9'(MCLK_TMO_CYC);
    else if (mclk_ok) mto_q <= mto_q - 9'h1;
  end

  // ---------------------------------------------------------------
  // Parallel port
  // ---------------------------------------------------------------
  cims_reg_if rif ();
  cims_regfile u_regs (.clk(clk), .rst_n(rst_n), .rif(rif));
  logic [ADDR_W-1:0] alat_q;
  cims_pstate_e      pst_q;
  logic [3:0]        wcnt_q;
  logic              armed_q;
  // Strobe+direction when style strap is low, split strobes when high.
  wire acc_rd = sty_q ? ~s_rd : (~s_wr & s_rd);
  wire acc_wr = sty_q ? ~s_wr : (~s_wr & ~s_rd);
  wire [ADDR_W-1:0] par_addr = mux_q ? alat_q : s_addr;
  wire acc_go = par_sel & armed_q & (acc_rd | acc_wr) & (pst_q == PA_IDLE);
  wire par_we = par_sel & acc_wr & (pst_q != PA_DONE) &
                ((pst_q == PA_WAIT & wcnt_q == 4'h0) | (acc_go & ~mclk_ok));
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alat_q  <= '0;
      pst_q   <= PA_IDLE;
      wcnt_q  <= 4'h0;
      armed_q <= 1'b0;
    end else begin
      if (par_sel & mux_q & ale_fell) alat_q <= s_data[ADDR_W-1:0];
      if (cs_fell) armed_q <= 1'b1;
      else if (acc_go) armed_q <= 1'b0;
      unique case (pst_q)
        PA_IDLE: begin
          if (acc_go) begin
            pst_q  <= mclk_ok ? PA_WAIT : PA_DONE;
            wcnt_q <= 4'(WAIT_CYC - 1);
          end
        end
        PA_WAIT: begin
          if (!par_sel) pst_q <= PA_IDLE;
          else if (wcnt_q == 4'h0) pst_q <= PA_DONE;
          else wcnt_q <= wcnt_q - 4'h1;
        end
        PA_DONE: if (!(par_sel & (acc_rd | acc_wr))) pst_q <= PA_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Serial port
  // ---------------------------------------------------------------
  logic [4:0]        bcnt_q;
  logic [7:0]        sin_q, sout_q, cmd_q;
  logic              sdo_en_q;
  wire               launch = s_edge ? cims_fell(prev_q[22], sync_q[22]) : sclk_rise;
  wire               ser_we = ser_sel & sclk_rise & (bcnt_q == 5'hf) & ~cmd_q[CMD_RD_BIT];
  always_ff @(posedge clk) begin
    if (!rst_n || !ser_sel) begin
      bcnt_q <= 5'h0;
      sin_q  <= 8'h00;
      sout_q <= 8'h00;
      cmd_q  <= 8'h00;
      sdo_en_q <= 1'b0;
    end else begin
      // The first launch edge of the data phase shows the top bit; later ones shift.
      if (launch && bcnt_q >= 5'h8 && cmd_q[CMD_RD_BIT]) sdo_en_q <= 1'b1;
      if (sclk_rise) begin
        sin_q <= {sin_q[6:0], s_sdi};
        if (bcnt_q != 5'h10) bcnt_q <= bcnt_q + 5'h1;
        if (bcnt_q == 5'h7) cmd_q <= {sin_q[6:0], s_sdi};
      end
      if (bcnt_q == 5'h8 && !launch) sout_q <= rif.rdata;
      else if (launch && bcnt_q > 5'h8) sout_q <= {sout_q[6:0], 1'b0};
    end
  end

  assign rif.we    = par_we | ser_we;
  assign rif.addr  = (meth_q == CIMS_SER) ? cmd_q[ADDR_W-1:0] : par_addr;
  assign rif.wdata = (meth_q == CIMS_SER) ? {sin_q[6:0], s_sdi} : s_data;

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  wire sdo_drv = ser_sel & sdo_en_q;
  wire hw_mode = (meth_q == CIMS_HW);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_data_out     <= 8'h00;
      host_data_oe      <= 1'b0;
      serial_data_out   <= 1'b0;
      serial_data_oe    <= 1'b0;
      int_n             <= 1'b1;
      ready_ack         <= 1'b1;
      method            <= 2'h0;
      cfg_template      <= 3'h0;
      cfg_clock_edge    <= 1'b0;
      cfg_output_enable <= 1'b0;
      efe_ok            <= 1'b0;
    end else begin
      host_data_out     <= rif.rdata;
      host_data_oe      <= par_sel & acc_rd & (pst_q == PA_DONE);
      serial_data_out   <= sdo_drv ? sout_q[7] : 1'b0;
      serial_data_oe    <= sdo_drv;
      int_n             <= ~(irq_req & ~hw_mode);
      ready_ack         <= (pst_q != PA_WAIT);
      method            <= meth_q;
      cfg_template      <= hw_mode ? s_ts : rif.cfg[CFG_TS_LSB +: 3];
      cfg_clock_edge    <= hw_mode ? s_edge : rif.cfg[CFG_EDGE_BIT];
      cfg_output_enable <= hw_mode ? s_oe : rif.cfg[CFG_OE_BIT];
      efe_ok            <= rif.efe_ok;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_method_decode: assert property (capture |=> meth_q == $past(meth_d))
    else $error("method not taken from strap level");
  a_strap_stable: assert property (boot_q == 2'h3 |=> $stable(meth_q) && $stable(mux_q))
    else $error("control method changed after capture");
  a_mux_latch: assert property (par_sel && mux_q && ale_fell |=> alat_q == $past(s_data[4:0]))
    else $error("multiplexed address not latched");
  a_nm_addr: assert property (meth_q == CIMS_PAR && (par_code == PAR_NM_DS || par_code == PAR_NM_RW) |-> rif.addr == s_addr)
    else $error("non-multiplexed address not from address pins");
  a_style_rw: assert property (sty_q && !s_rd && s_wr |-> acc_rd && !acc_wr)
    else $error("split strobe decode wrong");
  a_cs_ignore: assert property (s_cs_n |-> !rif.we ##1 !host_data_oe)
    else $error("host activity accepted with chip select high");
  a_no_wait: assert property (!mclk_ok && pst_q == PA_IDLE |=> ready_ack [*2])
    else $error("wait state without master clock");
  a_wait_len: assert property (acc_go && mclk_ok |=> pst_q == PA_WAIT ##[1:12] pst_q != PA_WAIT)
    else $error("wait state too long");
  a_hw_cfg: assert property (hw_mode |=> cfg_template == $past(s_ts))
    else $error("hardware template not from pins");
  a_sdo_quiet: assert property (!ser_sel |=> !serial_data_oe)
    else $error("serial output driven while deselected");
  a_sdi_sample: assert property (ser_sel && sclk_rise |=> sin_q[0] == $past(s_sdi))
    else $error("serial input not sampled on rising clock");

  c_par_write: cover property (par_we && meth_q == CIMS_PAR);
  c_ser_read:  cover property (sdo_drv && launch);
  c_wait:      cover property (pst_q == PA_WAIT ##1 pst_q == PA_DONE);
  c_mux_latch: cover property (par_sel && mux_q && ale_fell);
endmodule : cims_ctrl_if
`default_nettype wire

/* sim/cims_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cims_host_model (
  input  wire logic                        clk,
  input  wire logic                        ready_ack,
  input  wire logic [cims_pkg::DATA_W-1:0] host_data_out,
  input  wire logic                        serial_data_out,
  input  wire logic                        clock_edge_select,
  output logic                             cs_n,
  output logic                             sclk_ale,
  output logic                             serial_data_in,
  output logic                             write_or_data_strobe,
  output logic                             read_or_dir,
  output logic [cims_pkg::ADDR_W-1:0]      host_addr,
  output logic [cims_pkg::DATA_W-1:0]      host_data_in,
  output logic                             mclk
);
  import cims_pkg::*;
  logic       mclk_on = 1'b0;
  int         wait_cnt;
  logic [7:0] rd_q;
  initial begin
    {cs_n, sclk_ale, serial_data_in, write_or_data_strobe, read_or_dir, mclk} = 6'h26;
    {host_addr, host_data_in} = 13'h0;
  end
  // The reference clock stands still while it is switched off.
  always #244 if (mclk_on) mclk = ~mclk;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // One parallel access; the strobe is held for a fixed 20 clocks, long enough to outlast the wait state.
  task automatic par(input logic rd, st, mx, sel, input logic [4:0] a, input logic [7:0] d);
    step(1);
    cs_n = ~sel;
    sclk_ale = 1'b1;
    host_addr = mx ? ~a : a;
    host_data_in = mx ? {3'h5, a} : d;
    step(4);
    if (mx) begin
      sclk_ale = 1'b0;
      step(4);
      host_data_in = d;
    end
    read_or_dir = st ? ~rd : rd;
    write_or_data_strobe = st & rd;
    wait_cnt = 0;
    repeat (20) begin
      step(1);
      wait_cnt += int'(ready_ack === 1'b0);
    end
    rd_q = host_data_out;
    {write_or_data_strobe, read_or_dir, sclk_ale} = 3'h7;
    step(4);
    cs_n = 1'b1;
    host_addr = ~host_addr;
    host_data_in = ~host_data_in;
    step(4);
  endtask : par
  // One serial frame of 17 clocks; read bits are taken half a shift clock after each launch edge.
  task automatic ser(input logic rd, input logic [4:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {rd, 2'h0, a, d};
    step(1);
    sclk_ale = 1'b0;
    step(1);
    cs_n = 1'b0;
    for (int i = 1; i <= 17; i++) begin
      serial_data_in = f[15];
      f = f << 1;
      #40;
      if (clock_edge_select && i >= 9 && i <= 16) rd_q = {rd_q[6:0], serial_data_out};
      sclk_ale = 1'b1;
      #40;
      if (!clock_edge_select && i >= 9 && i <= 16) rd_q = {rd_q[6:0], serial_data_out};
      sclk_ale = 1'b0;
    end
    serial_data_in = ~serial_data_in;
    #40;
    cs_n = 1'b1;
    step(4);
  endtask : ser
endmodule : cims_host_model
`default_nettype wire

/* sim/control_interface_mode_select_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module control_interface_mode_select_tb_top;
  import cims_pkg::*;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic [1:0]      method_level = 2'h0;
  logic            bus_multiplex_strap = 1'b0;
  logic            bus_style_strap = 1'b0;
  logic [2:0]      template_select = 3'h5;
  logic            clock_edge_select = 1'b1;
  logic            output_enable_pin = 1'b0;
  logic            irq_req = 1'b1;
  wire logic       cs_n, sclk_ale, serial_data_in, write_or_data_strobe, read_or_dir, mclk;
  wire logic [4:0] host_addr;
  wire logic [7:0] host_data_in, host_data_out;
  wire logic       host_data_oe, serial_data_out, serial_data_oe, int_n, ready_ack, efe_ok;
  wire logic [1:0] method;
  wire logic [2:0] cfg_template;
  wire logic       cfg_clock_edge, cfg_output_enable;
  int              bad_count = 0;
  int              total_checks = 0;
  int              cyc = 0;
  logic [2:0]      c;
  logic [7:0]      v;
  cims_ctrl_if uut (
    .clk(clk), .rst_n(rst_n), .method_level(method_level), .bus_multiplex_strap(bus_multiplex_strap),
    .bus_style_strap(bus_style_strap), .cs_n(cs_n), .sclk_ale(sclk_ale), .serial_data_in(serial_data_in),
    .write_or_data_strobe(write_or_data_strobe), .read_or_dir(read_or_dir), .host_addr(host_addr),
    .host_data_in(host_data_in), .template_select(template_select), .clock_edge_select(clock_edge_select),
    .output_enable_pin(output_enable_pin), .mclk(mclk), .irq_req(irq_req), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .int_n(int_n), .ready_ack(ready_ack), .method(method), .cfg_template(cfg_template),
    .cfg_clock_edge(cfg_clock_edge), .cfg_output_enable(cfg_output_enable), .efe_ok(efe_ok));
  cims_host_model host (
    .clk(clk), .ready_ack(ready_ack), .host_data_out(host_data_out), .serial_data_out(serial_data_out),
    .clock_edge_select(clock_edge_select), .cs_n(cs_n), .sclk_ale(sclk_ale), .serial_data_in(serial_data_in),
    .write_or_data_strobe(write_or_data_strobe), .read_or_dir(read_or_dir), .host_addr(host_addr),
    .host_data_in(host_data_in), .mclk(mclk));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // Reset for 8 cycles with the straps set, then let capture settle.
  task automatic boot(input logic [1:0] lvl, input logic mx, input logic st);
    host.step(1);
    rst_n = 1'b0;
    method_level = lvl;
    bus_multiplex_strap = mx;
    bus_style_strap = st;
    host.step(8);
    chk(ready_ack, 1'b1);
    chk(int_n, 1'b1);
    chk(efe_ok, 1'b0);
    rst_n = 1'b1;
    host.step(8);
  endtask : boot
  initial begin
    boot(LVL_LOW, 1'b0, 1'b0);
    chk(method, CIMS_HW);
    chk(cfg_template, 3'h5);
    chk(cfg_clock_edge, 1'b1);
    chk(cfg_output_enable, 1'b0);
    chk(int_n, 1'b1);
    $display("test hardware mode done");
    for (int k = 4; k < 8; k++) begin
      c = 3'(k);
      host.mclk_on = c[1] ~^ c[0];
      boot(LVL_HIGH, c[1], c[0]);
      chk(method, CIMS_PAR);
      // Give the presence timer time to see the master clock, or to run out.
      host.step(300);
      host.par(1'b1, c[0], c[1], 1'b1, EFE_ADDR, 8'h00);
      chk(host.rd_q, REG_RST);
      host.par(1'b0, c[0], c[1], 1'b1, EFE_ADDR, EFE_GOOD);
      chk(8'(host.wait_cnt), host.mclk_on ? 8'(WAIT_CYC) : 8'h00);
      chk(efe_ok, 1'b1);
      host.par(1'b0, c[0], c[1], 1'b0, CFG_ADDR, 8'h1d);
      chk(cfg_template, 3'h0);
      host.par(1'b0, c[0], c[1], 1'b1, CFG_ADDR, 8'h1d);
      chk(cfg_template, 3'h5);
      chk(cfg_clock_edge, 1'b1);
      chk(cfg_output_enable, 1'b1);
      host.par(1'b1, c[0], c[1], 1'b1, CFG_ADDR, 8'h00);
      chk(host.rd_q, 8'h1d);
      chk(host_data_oe, 1'b0);
      chk(int_n, 1'b0);
      method_level = LVL_LOW;
      host.step(4);
      chk(method, CIMS_PAR);
      $display("test parallel code %b done", c);
    end
    boot(LVL_MID, 1'b0, 1'b0);
    chk(method, CIMS_SER);
    for (int e = 0; e < 2; e++) begin
      clock_edge_select = e[0];
      v = e[0] ? 8'h13 : 8'h0a;
      host.ser(1'b0, CFG_ADDR, v);
      chk(cfg_template, v[2:0]);
      host.ser(1'b1, CFG_ADDR, 8'h00);
      chk(host.rd_q, v);
      chk(serial_data_oe, 1'b0);
      chk(int_n, 1'b0);
      $display("test serial edge %0d done", e);
    end
    irq_req = 1'b0;
    host.step(2);
    chk(int_n, 1'b1);
    $display("test interrupt release done");
    end_of_test();
  end
endmodule : control_interface_mode_select_tb_top
`default_nettype wire
